// file: rtl/timer_b_unit.sv
// Purpose: Register tail of a 16-bit capture/compare timer
// Assumes: Avalon-MM slave, one wait state per access
// Notes:   capture_event and cpu_halted come from clk-domain logic
//
// Design decision made here: the Avalon-MM register port.
`default_nettype none

module timer_b_unit
  import timer_b_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              capture_event,
  input  wire logic              cpu_halted,
  output logic                   capture_irq
);

  // ==========================================================
  // Declarations
  typedef enum logic [1:0] {PH_WAIT, PH_FIRST, PH_SECOND, PH_DONE} phase_t;

  logic              ack_q;
  logic              rd_go;
  logic              wr_go;
  logic [IDX_W-1:0]  idx;
  logic [7:0]        wdat;
  logic [7:0]        rd_byte;
  logic [31:0]       readdata_q;
  logic [7:0]        hi_snap_q;

  logic              enable_q;
  logic [2:0]        counting_mode_select_q;
  logic              capture_event_input_en_q;
  logic              edge_sel_q;
  logic              irq_en_q;
  logic              flag_q;
  logic              continue_on_halt_q;
  logic [7:0]        stage_q;
  logic [15:0]       cnt_q;
  logic [15:0]       capture_compare_value_reg_q;
  logic              gate_q;
  logic              gate_d;
  phase_t            phase_q;
  phase_t            phase_d;
  logic              ev_prev_q;

  logic              frozen;
  logic              active;
  logic              ev_ok;
  logic              ev_rise;
  logic              ev_fall;
  logic              act_ev;
  logic              opp_ev;
  logic [15:0]       cnt_d;
  logic              cap_ld;
  logic              flag_set;
  logic              flag_clr;
  logic              pwm8;
  logic              capture_irq_mode;
  logic              running;
  logic [15:0]       cnt_inc;

  // ==========================================================
  // Bus handshake
  assign idx             = avs_address[IDX_LSB +: IDX_W];
  assign wdat            = avs_writedata[7:0];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign rd_go           = avs_read & ack_q;
  assign wr_go           = avs_write & ack_q & avs_byteenable[0];
  assign avs_readdata    = readdata_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  // ==========================================================
  // Read data
  always_comb begin
    rd_byte = RESET_BYTE;
    case (idx)
      IDX_CTRL_A:  rd_byte[BIT_ENABLE] = enable_q;
      IDX_CTRL_B:  rd_byte[MODE_LSB +: MODE_W] = counting_mode_select_q;
      IDX_EV_CTRL: begin
        rd_byte[BIT_CEI_EN] = capture_event_input_en_q;
        rd_byte[BIT_EDGE]   = edge_sel_q;
      end
      IDX_IRQ_EN:  rd_byte[BIT_CAPTURE_IRQ] = irq_en_q;
      IDX_FLAG:    rd_byte[BIT_CAPTURE_IRQ] = flag_q;
      IDX_RUN:     rd_byte[BIT_RUN] = running;
      IDX_HALT:    rd_byte[BIT_CONT] = continue_on_halt_q;
      IDX_STAGE:   rd_byte = stage_q;
      IDX_CNT_L:   rd_byte = cnt_q[7:0];
      IDX_CNT_H:   rd_byte = stage_q;
      IDX_CAPTURE_COMPARE_VALUE_REG_L:  rd_byte = capture_compare_value_reg_q[7:0];
      IDX_CAPTURE_COMPARE_VALUE_REG_H:  rd_byte = pwm8 ? capture_compare_value_reg_q[15:8] : stage_q;
      default:     rd_byte = RESET_BYTE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      readdata_q <= 32'h0000_0000;
      hi_snap_q  <= RESET_BYTE;
    end else if (avs_read & ~ack_q) begin
      readdata_q <= {24'h00_0000, rd_byte};
      hi_snap_q  <= (idx == IDX_CAPTURE_COMPARE_VALUE_REG_L) ? capture_compare_value_reg_q[15:8] : cnt_q[15:8];
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_q                 <= 1'b0;
      counting_mode_select_q   <= MODE_PERIODIC;
      capture_event_input_en_q <= 1'b0;
      edge_sel_q               <= 1'b0;
      irq_en_q                 <= 1'b0;
      continue_on_halt_q       <= 1'b0;
    end else if (wr_go) begin
      case (idx)
        IDX_CTRL_A:  enable_q <= wdat[BIT_ENABLE];
        IDX_CTRL_B:  counting_mode_select_q <= wdat[MODE_LSB +: MODE_W];
        IDX_EV_CTRL: begin
          capture_event_input_en_q <= wdat[BIT_CEI_EN];
          edge_sel_q               <= wdat[BIT_EDGE];
        end
        IDX_IRQ_EN:  irq_en_q <= wdat[BIT_CAPTURE_IRQ];
        IDX_HALT:    continue_on_halt_q <= wdat[BIT_CONT];
        default:     ;
      endcase
    end
  end

  // ==========================================================
  // Event edges
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ev_prev_q <= 1'b0;
    end else begin
      ev_prev_q <= capture_event;
    end
  end

  assign pwm8      = (counting_mode_select_q == MODE_PWM8);
  assign capture_irq_mode = (counting_mode_select_q == MODE_CAPTURE) |
                     (counting_mode_select_q == MODE_FREQ) |
                     (counting_mode_select_q == MODE_PULSE) |
                     (counting_mode_select_q == MODE_FREQ_PULSE);
  assign frozen    = cpu_halted & ~continue_on_halt_q;
  assign active    = enable_q & ~frozen;
  assign ev_ok     = active & capture_event_input_en_q;
  assign ev_rise   = capture_event & ~ev_prev_q;
  assign ev_fall   = ~capture_event & ev_prev_q;
  assign act_ev    = ev_ok & (edge_sel_q ? ev_fall : ev_rise);
  assign opp_ev    = ev_ok & (edge_sel_q ? ev_rise : ev_fall);
  assign cnt_inc   = cnt_q + ONE_WORD;

  // ==========================================================
  // Counting per mode
  always_comb begin
    cnt_d    = cnt_q;
    cap_ld   = 1'b0;
    flag_set = 1'b0;
    gate_d   = gate_q;
    phase_d  = phase_q;
    if (!enable_q) begin
      gate_d  = 1'b0;
      phase_d = PH_WAIT;
    end else if (active) begin
      case (counting_mode_select_q)
        MODE_PERIODIC: begin
          if (cnt_q == capture_compare_value_reg_q) begin
            flag_set = 1'b1;
            cnt_d    = RESET_WORD;
          end else begin
            cnt_d = cnt_inc;
          end
        end
        MODE_TIMEOUT: begin
          if (act_ev) begin
            gate_d = 1'b1;
          end else if (opp_ev) begin
            gate_d = 1'b0;
          end
          if (gate_q) begin
            if (cnt_q == capture_compare_value_reg_q) begin
              flag_set = 1'b1;
              cnt_d    = RESET_WORD;
            end else begin
              cnt_d = cnt_inc;
            end
          end
        end
        MODE_CAPTURE: begin
          cnt_d = cnt_inc;
          if (act_ev) begin
            cap_ld   = 1'b1;
            flag_set = 1'b1;
          end
        end
        MODE_FREQ: begin
          if (act_ev) begin
            cap_ld   = 1'b1;
            flag_set = 1'b1;
            cnt_d    = RESET_WORD;
          end else begin
            cnt_d = cnt_inc;
          end
        end
        MODE_PULSE: begin
          if (act_ev) begin
            cnt_d = RESET_WORD;
          end else begin
            cnt_d = cnt_inc;
            if (opp_ev) begin
              cap_ld   = 1'b1;
              flag_set = 1'b1;
            end
          end
        end
        MODE_FREQ_PULSE: begin
          case (phase_q)
            PH_WAIT: begin
              if (act_ev) begin
                cnt_d   = RESET_WORD;
                phase_d = PH_FIRST;
              end
            end
            PH_FIRST: begin
              cnt_d = cnt_inc;
              if (opp_ev) begin
                cap_ld  = 1'b1;
                phase_d = PH_SECOND;
              end
            end
            PH_SECOND: begin
              if (act_ev) begin
                flag_set = 1'b1;
                phase_d  = PH_DONE;
              end else begin
                cnt_d = cnt_inc;
              end
            end
            PH_DONE: begin
              if (!flag_q) begin
                phase_d = PH_WAIT;
              end
            end
            default: phase_d = PH_WAIT;
          endcase
        end
        MODE_SINGLE: begin
          if (gate_q) begin
            if (cnt_q == capture_compare_value_reg_q) begin
              flag_set = 1'b1;
              gate_d   = 1'b0;
            end else begin
              cnt_d = cnt_inc;
            end
          end else if (act_ev) begin
            gate_d = 1'b1;
            cnt_d  = RESET_WORD;
          end
        end
        MODE_PWM8: begin
          if (cnt_q[7:0] == capture_compare_value_reg_q[7:0]) begin
            flag_set = 1'b1;
            cnt_d    = RESET_WORD;
          end else begin
            cnt_d = {8'h00, cnt_inc[7:0]};
          end
        end
        default: cnt_d = cnt_q;
      endcase
    end
  end

  always_comb begin
    running = 1'b0;
    if (active) begin
      case (counting_mode_select_q)
        MODE_TIMEOUT, MODE_SINGLE: running = gate_q;
        MODE_FREQ_PULSE: running = (phase_q == PH_FIRST) | (phase_q == PH_SECOND);
        default: running = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gate_q  <= 1'b0;
      phase_q <= PH_WAIT;
    end else begin
      gate_q  <= gate_d;
      phase_q <= (counting_mode_select_q == MODE_FREQ_PULSE) ? phase_d : PH_WAIT;
    end
  end

  // ==========================================================
  // Counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= RESET_WORD;
    end else if (wr_go && idx == IDX_CNT_H) begin
      cnt_q <= {wdat, stage_q};
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // Capture/compare
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      capture_compare_value_reg_q <= RESET_WORD;
    end else if (wr_go && idx == IDX_CAPTURE_COMPARE_VALUE_REG_H) begin
      if (pwm8) begin
        capture_compare_value_reg_q[15:8] <= wdat;
      end else begin
        capture_compare_value_reg_q <= {wdat, stage_q};
      end
    end else if (wr_go && idx == IDX_CAPTURE_COMPARE_VALUE_REG_L && pwm8) begin
      capture_compare_value_reg_q[7:0] <= wdat;
    end else if (cap_ld) begin
      capture_compare_value_reg_q <= cnt_q;
    end
  end

  // ==========================================================
  // Staging byte
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage_q <= RESET_BYTE;
    end else if (wr_go && (idx == IDX_STAGE || idx == IDX_CNT_L ||
                           (idx == IDX_CAPTURE_COMPARE_VALUE_REG_L && !pwm8))) begin
      stage_q <= wdat;
    end else if (rd_go && (idx == IDX_CNT_L || (idx == IDX_CAPTURE_COMPARE_VALUE_REG_L && !pwm8))) begin
      stage_q <= hi_snap_q;
    end
  end

  // ==========================================================
  // Capture flag and request
  assign flag_clr = (wr_go && idx == IDX_FLAG && wdat[BIT_CAPTURE_IRQ]) ||
                    (rd_go && capture_irq_mode &&
                     (idx == IDX_CAPTURE_COMPARE_VALUE_REG_L || idx == IDX_CAPTURE_COMPARE_VALUE_REG_H));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_set | (flag_q & ~flag_clr);
    end
  end

  assign capture_irq = flag_q & irq_en_q;

endmodule

`default_nettype wire

// file: rtl/timer_b_pkg.sv
// Purpose: Shared constants for the timer_b_unit register tail
// Assumes: Byte-wide registers, one per aligned 32-bit Avalon word
// Notes:   Byte address of a register is four times its index
`default_nettype none

package timer_b_pkg;

  // ==========================================================
  // Bus geometry
  localparam int          ADDR_W       = 6;
  localparam int          IDX_LSB      = 2;
  localparam int          IDX_W        = 4;

  // ==========================================================
  // Register indices
  localparam logic [3:0]  IDX_CTRL_A   = 4'h0;
  localparam logic [3:0]  IDX_CTRL_B   = 4'h1;
  localparam logic [3:0]  IDX_EV_CTRL  = 4'h4;
  localparam logic [3:0]  IDX_IRQ_EN   = 4'h5;
  localparam logic [3:0]  IDX_FLAG     = 4'h6;
  localparam logic [3:0]  IDX_RUN      = 4'h7;
  localparam logic [3:0]  IDX_HALT     = 4'h8;
  localparam logic [3:0]  IDX_STAGE    = 4'h9;
  localparam logic [3:0]  IDX_CNT_L    = 4'ha;
  localparam logic [3:0]  IDX_CAPTURE_COMPARE_VALUE_REG_L   = 4'hc;
  localparam logic [3:0]  IDX_HIGH_OFS = 4'h1;
  localparam logic [3:0]  IDX_CNT_H    = IDX_CNT_L + IDX_HIGH_OFS;
  localparam logic [3:0]  IDX_CAPTURE_COMPARE_VALUE_REG_H   = IDX_CAPTURE_COMPARE_VALUE_REG_L + IDX_HIGH_OFS;

  // ==========================================================
  // Field positions
  localparam int          BIT_ENABLE   = 0;
  localparam int          BIT_CAPTURE_IRQ     = 0;
  localparam int          BIT_RUN      = 0;
  localparam int          BIT_CONT     = 0;
  localparam int          BIT_CEI_EN   = 0;
  localparam int          BIT_EDGE     = 4;
  localparam int          MODE_LSB     = 0;
  localparam int          MODE_W       = 3;

  // ==========================================================
  // Counting modes
  localparam logic [2:0]  MODE_PERIODIC   = 3'h0;
  localparam logic [2:0]  MODE_TIMEOUT    = 3'h1;
  localparam logic [2:0]  MODE_CAPTURE    = 3'h2;
  localparam logic [2:0]  MODE_FREQ       = 3'h3;
  localparam logic [2:0]  MODE_PULSE      = 3'h4;
  localparam logic [2:0]  MODE_FREQ_PULSE = 3'h5;
  localparam logic [2:0]  MODE_SINGLE     = 3'h6;
  localparam logic [2:0]  MODE_PWM8       = 3'h7;

  // ==========================================================
  // Reset values and counter increment
  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  localparam logic [15:0] RESET_WORD   = 16'h0000;
  localparam logic [15:0] ONE_WORD     = 16'h0001;

endpackage

`default_nettype wire

// file: verif/timer_b_unit_asserts.sv
// Purpose: Port-level checks for timer_b_unit
// Assumes: Master holds each request until waitrequest is low
// Notes:   Bound to every timer_b_unit instance
`default_nettype none

module timer_b_unit_asserts
  import timer_b_pkg::*;
(
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              capture_event,
  input wire logic              cpu_halted,
  input wire logic              capture_irq
);
  // ==========================================================
  // Helpers
  logic       req;
  logic [3:0] idx;
  logic       rd_ack;
  assign req    = avs_read | avs_write;
  assign idx    = avs_address[5:2];
  assign rd_ack = avs_read & ~avs_waitrequest;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // Properties
  property p_wait_first; req && !$past(req) |-> avs_waitrequest; endproperty
  property p_wait_one; req && avs_waitrequest |=> !req || !avs_waitrequest; endproperty
  property p_wait_idle; !req |-> !avs_waitrequest; endproperty
  property p_rd_upper; avs_readdata[31:8] == 24'h0; endproperty
  property p_rd_hold; !avs_read |=> $stable(avs_readdata); endproperty
  property p_unmapped;
    rd_ack && idx inside {4'h2, 4'h3, 4'he, 4'hf} |-> avs_readdata == 32'h0;
  endproperty
  property p_run_ro; rd_ack && idx == IDX_RUN |-> avs_readdata[7:1] == 7'h0; endproperty
  property p_irq_mask;
    avs_write && !avs_waitrequest && idx == IDX_IRQ_EN && avs_byteenable[0]
      && !avs_writedata[BIT_ENABLE] |=> !capture_irq [*2];
  endproperty

  a_wait_first: assert property (p_wait_first) else $error("no wait state on first cycle");
  a_wait_one: assert property (p_wait_one) else $error("more than one wait state");
  a_wait_idle: assert property (p_wait_idle) else $error("waitrequest without request");
  a_rd_upper: assert property (p_rd_upper) else $error("readdata upper bits set");
  a_rd_hold: assert property (p_rd_hold) else $error("readdata changed without read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_run_ro: assert property (p_run_ro) else $error("run register spare bits set");
  a_irq_mask: assert property (p_irq_mask) else $error("irq with enable clear");

  c_irq: cover property ($rose(capture_irq));
  c_rd: cover property (rd_ack);
  c_wr: cover property (avs_write && !avs_waitrequest);
endmodule

bind timer_b_unit timer_b_unit_asserts u_chk (
  .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .capture_event(capture_event), .cpu_halted(cpu_halted), .capture_irq(capture_irq)
);

`default_nettype wire

// file: verif/tb_timer_b_unit.sv
// Purpose: Self-checking bench for timer_b_unit
// Assumes: One wait state bus, timer clocked every cycle
// Notes:   Row table first, then reset and timing cases
`default_nettype none

module tb_timer_b_unit
  import timer_b_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {logic [3:0] idx; logic [7:0] wd; logic [7:0] ex;} row_t;

  logic              clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic              capture_event, cpu_halted, capture_irq;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0]       avs_writedata, avs_readdata;
  logic [3:0]        avs_byteenable;
  logic [7:0]        rv, rv0;
  int                fails, n_tests;
  time               t1, t2;
  row_t              rows [6] = '{'{IDX_IRQ_EN, 8'h01, 8'h01}, '{IDX_HALT, 8'h01, 8'h01},
    '{IDX_STAGE, 8'ha5, 8'ha5}, '{IDX_RUN, 8'hff, 8'h00}, '{4'h2, 8'h5a, 8'h00},
    '{4'hf, 8'h5a, 8'h00}};

  timer_b_unit u_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .capture_event(capture_event),
    .cpu_halted(cpu_halted), .capture_irq(capture_irq));

  // ==========================================================
  // Tasks
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chkb(input logic g, input logic e);
    chk({15'h0000, g}, {15'h0000, e});
  endtask

  task automatic bus(input logic wr, input logic [3:0] i, input logic [7:0] d);
    int k;
    @(posedge clk);
    avs_address   <= {i, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write     <= wr;
    avs_read      <= !wr;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) fails++;
    rv = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic rdc(input logic [3:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk({8'h0, rv}, {8'h0, e});
  endtask

  task automatic pulse;
    @(posedge clk);
    capture_event <= 1'b1;
    repeat (4) @(posedge clk);
    capture_event <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wirq(output time t);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (capture_irq !== 1'b1 && k < 100);
    if (k >= 100) fails++;
    t = $time;
  endtask

  // ==========================================================
  // Clock, watchdog, sequence
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done();
  end

  initial begin
    fails = 0; n_tests = 0; sys_rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0;
    avs_address = '0; avs_writedata = '0; avs_byteenable = 4'h1;
    capture_event = 1'b0; cpu_halted = 1'b0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[r]) begin
      bus(1'b1, rows[r].idx, rows[r].wd);
      rdc(rows[r].idx, rows[r].ex);
    end
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, IDX_CTRL_B, 8'(m));
      rdc(IDX_CTRL_B, 8'(m));
    end
    avs_byteenable <= 4'h0;
    bus(1'b1, IDX_STAGE, 8'h3c);
    avs_byteenable <= 4'h1;
    rdc(IDX_STAGE, 8'ha5);
    // Mid-run reset, then reset values
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 5; i < 14; i++) rdc(4'(i), 8'h00);
    bus(1'b1, IDX_CNT_L, 8'h34);
    bus(1'b1, IDX_CNT_H, 8'h12);
    rdc(IDX_CNT_L, 8'h34);
    rdc(IDX_STAGE, 8'h12);
    rdc(IDX_CNT_H, 8'h12);
    // Capture on event, running counter
    bus(1'b1, IDX_IRQ_EN, 8'h01);
    bus(1'b1, IDX_CTRL_B, 8'(MODE_CAPTURE));
    bus(1'b1, IDX_CTRL_A, 8'h01);
    bus(1'b1, IDX_CNT_L, 8'h00);
    bus(1'b1, IDX_CNT_H, 8'h12);
    bus(1'b0, IDX_CNT_L, 8'h00);
    rdc(IDX_CNT_H, 8'h12);
    pulse();
    chkb(capture_irq, 1'b0);
    bus(1'b1, IDX_EV_CTRL, 8'h01);
    pulse();
    chkb(capture_irq, 1'b1);
    bus(1'b0, IDX_CAPTURE_COMPARE_VALUE_REG_L, 8'h00);
    rdc(IDX_CAPTURE_COMPARE_VALUE_REG_H, 8'h12);
    chkb(capture_irq, 1'b0);
    // Frequency and pulse width: period 9, width 4
    for (int m = 3; m < 5; m++) begin
      bus(1'b1, IDX_CTRL_B, 8'(m));
      pulse();
      pulse();
      bus(1'b0, IDX_CAPTURE_COMPARE_VALUE_REG_L, 8'h00);
      chkb(rv >= 8'(m == 3 ? 7 : 2) && rv <= 8'(m == 3 ? 11 : 6), 1'b1);
    end
    // Falling edge active: combined mode, low time 5
    bus(1'b1, IDX_EV_CTRL, 8'h11);
    bus(1'b1, IDX_CTRL_B, 8'(MODE_FREQ_PULSE));
    pulse();
    pulse();
    chkb(capture_irq, 1'b1);
    bus(1'b0, IDX_CNT_L, 8'h00);
    rv0 = rv;
    rdc(IDX_CNT_L, rv0);
    bus(1'b0, IDX_CAPTURE_COMPARE_VALUE_REG_L, 8'h00);
    chkb(rv >= 8'h03 && rv <= 8'h06, 1'b1);
    // Timeout, then single-shot, top 5
    bus(1'b1, IDX_CAPTURE_COMPARE_VALUE_REG_L, 8'h05);
    bus(1'b1, IDX_CAPTURE_COMPARE_VALUE_REG_H, 8'h00);
    for (int m = 1; m < 7; m += 5) begin
      bus(1'b1, IDX_CTRL_B, 8'(m));
      bus(1'b1, IDX_CNT_L, 8'h00);
      bus(1'b1, IDX_CNT_H, 8'h00);
      bus(1'b1, IDX_FLAG, 8'h01);
      pulse();
      wirq(t1);
      rdc(IDX_RUN, 8'(m == 1));
    end
    rdc(IDX_CNT_L, 8'h05);
    // Periodic top 16, then PWM8 top 8
    bus(1'b1, IDX_EV_CTRL, 8'h00);
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, IDX_CTRL_B, 8'(j ? MODE_PWM8 : MODE_PERIODIC));
      bus(1'b1, IDX_CAPTURE_COMPARE_VALUE_REG_L, j ? 8'h08 : 8'h10);
      bus(1'b1, IDX_CAPTURE_COMPARE_VALUE_REG_H, j ? 8'h33 : 8'h00);
      bus(1'b1, IDX_CNT_L, 8'h00);
      bus(1'b1, IDX_CNT_H, 8'h00);
      bus(1'b1, IDX_FLAG, 8'h01);
      wirq(t1);
      bus(1'b1, IDX_FLAG, 8'h01);
      wirq(t2);
      chk(16'((t2 - t1) / 5), j ? 16'h0009 : 16'h0011);
    end
    rdc(IDX_CAPTURE_COMPARE_VALUE_REG_H, 8'h33);
    rdc(IDX_RUN, 8'h01);
    bus(1'b1, IDX_HALT, 8'h00);
    bus(1'b1, IDX_FLAG, 8'h01);
    cpu_halted <= 1'b1;
    repeat (30) @(negedge clk);
    chkb(capture_irq, 1'b0);
    bus(1'b1, IDX_HALT, 8'h01);
    bus(1'b1, IDX_FLAG, 8'h01);
    wirq(t1);
    chkb(capture_irq, 1'b1);
    bus(1'b1, IDX_IRQ_EN, 8'h00);
    cpu_halted <= 1'b0;
    @(negedge clk);
    chkb(capture_irq, 1'b0);
    test_done();
  end
endmodule

`default_nettype wire
